// file: verilog/sbp_dev.sv
// SRAM device end: command decode, burst write and read, lock, impedance
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Overview of operation
// R1: Address and commands sampled on true rises only
// R2: Both requests high means full deselect
// R3: Low read request starts four-beat read
// R4: Read ignored right after a loaded read
// R5: High read request gives read deselect
// R6: Write needs low write, high read; the code also takes a write while an ignored read holds rd_n low
// R7: Write ignored right after a loaded write
// R8: Write beats on true, comp, true, comp
// R9: Lane masks sampled with their data beat
// R10: Masked lane leaves stored bits unchanged
// R11: Each write address bases four beats
// R12: Controller may mask lanes per beat freely
// R13: Driver impedance steps once per evaluation
// R14: Termination follows the termination-enable pin
// R15: Termination impedance steps like driver impedance
// R16: Controller always drives data, masks, clocks
// R17: Controller waits clock settle time once
// R18: Controller waits 2048 clocks for lock
// R19: Loop reset repeats the 2048-cycle wait
// R20: Wide part: masks 0 to 3 govern lanes
// R21: Read beats from 2.5 cycles, else off
// R22: Deselect still completes earlier burst beats
module sbp_dev
    import sbp_pkg::*;
#(
    parameter int DW = 18,
    parameter int AW = 4,
    parameter int ZQ_EVAL = ZQ_EVAL_CYC
) (
    // Clock, reset and freeze
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Pins toward the controller
    sbp_link_if.dev lnk,
    // Board resistor seen as an optimum impedance code
    input wire logic [ZQ_W-1:0] impedance_resistor,
    // Status
    output logic locked,
    output logic term_on,
    output logic [ZQ_W-1:0] drv_imp,
    output logic [ZQ_W-1:0] term_imp
);
    localparam int LN = DW / LANE_W;
    localparam int DEPTH = (1 << AW) * BEATS;
    localparam int MW = AW + BEAT_IDX_W;
    localparam int EVAL_W = $clog2(ZQ_EVAL + 1);

    typedef struct packed {
        logic [DEPTH-1:0][DW-1:0] mem;
        logic [RD_PIPE-1:0] rd_v;
        logic [RD_PIPE-1:0][AW-1:0] rd_a;
        logic [WR_PIPE-1:0] wr_v;
        logic [WR_PIPE-1:0][AW-1:0] wr_a;
        logic prev_rd;
        logic prev_wr;
        logic [STOP_W-1:0] stop_cnt;
        logic [LOCK_W-1:0] lock_cnt;
        logic locked;
        logic [EVAL_W-1:0] eval_cnt;
        logic [ZQ_W-1:0] drv_imp;
        logic [ZQ_W-1:0] term_imp;
        logic term_on;
        logic [DW-1:0] q;
        logic q_oe;
    } sbp_dev_st_t;

    localparam sbp_dev_st_t ST_RST = '{
        drv_imp: ZQ_RESET,
        term_imp: ZQ_RESET,
        default: '0
    };

    sbp_dev_st_t s;
    sbp_dev_st_t next_s;
    logic rd_take;
    logic wr_take;
    logic clk_lost;

    // One calibration step toward the optimum code, never more
    function automatic logic [ZQ_W-1:0] zq_step(
        input logic [ZQ_W-1:0] cur,
        input logic [ZQ_W-1:0] tgt
    );
        if (cur < tgt) begin
            return cur + ZQ_W'(1);
        end else if (cur > tgt) begin
            return cur - ZQ_W'(1);
        end
        return cur;
    endfunction

    // Array row of one beat: base address in the upper bits, beat below
    function automatic logic [MW-1:0] mem_idx(
        input logic [AW-1:0] base,
        input int beat
    );
        return {base, BEAT_IDX_W'(beat)};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        next_s = s;
        rd_take = 1'b0;
        wr_take = 1'b0;
        clk_lost = 1'b0;

        // Pipes advance every half period so beats keep their own slots
        next_s.rd_v = {s.rd_v[RD_PIPE-2:0], 1'b0};
        next_s.rd_a = {s.rd_a[RD_PIPE-2:0], AW'(0)};
        next_s.wr_v = {s.wr_v[WR_PIPE-2:0], 1'b0};
        next_s.wr_a = {s.wr_a[WR_PIPE-2:0], AW'(0)};

        // Commands exist only on true rises; complement rises carry data
        if (lnk.k_clk) begin // [R1]
            // Both high falls through both takes: full deselect [R2]
            rd_take = s.locked && !lnk.rd_n && !s.prev_rd; // [R3] [R4] [R5]
            // A read that is being ignored does not block the write
            wr_take = s.locked && !lnk.wr_n && !s.prev_wr
                && (lnk.rd_n || s.prev_rd); // [R6] [R7]
            next_s.rd_v[0] = rd_take;
            next_s.rd_a[0] = lnk.loc_inputs;
            next_s.wr_v[0] = wr_take;
            next_s.wr_a[0] = lnk.loc_inputs;
            next_s.prev_rd = rd_take;
            next_s.prev_wr = wr_take;
        end

        // Write beats land two to five half periods after the command,
        // which is true, complement, true, complement in turn
        for (int k = 0; k < BEATS; k++) begin
            if (s.wr_v[WR_BEAT0_SLOT + k]) begin // [R8] [R11] [R22]
                for (int l = 0; l < LN; l++) begin
                    // Mask bit l guards data bits l*9 upward [R9] [R20]
                    if (!lnk.lane_mask_n[l]) begin // [R10]
                        next_s.mem[mem_idx(s.wr_a[WR_BEAT0_SLOT + k], k)]
                            [l*LANE_W +: LANE_W] =
                            lnk.d[l*LANE_W +: LANE_W];
                    end
                end
            end
        end

        // Read beats are staged one cycle early so q comes from a flop;
        // the array is read at beat time, so a write just ahead is seen
        next_s.q_oe = 1'b0;
        next_s.q = '0;
        for (int k = 0; k < BEATS; k++) begin
            if (s.rd_v[RD_BEAT0_SLOT + k]) begin // [R21] [R22]
                next_s.q_oe = 1'b1;
                next_s.q = s.mem[mem_idx(s.rd_a[RD_BEAT0_SLOT + k], k)];
            end
        end

        // Clock stop watch: a stop lasting CLK_STOP_CYC cycles resets the loop in its last cycle
        if (lnk.k_run) begin
            next_s.stop_cnt = '0;
        end else if (s.stop_cnt != STOP_W'(CLK_STOP_CYC)) begin
            next_s.stop_cnt = s.stop_cnt + STOP_W'(1);
        end
        clk_lost = !lnk.k_run
            && (s.stop_cnt >= STOP_W'(CLK_STOP_CYC - 1));

        // Loop lock: count true rises with the loop enabled
        if (!lnk.loop_enable || clk_lost) begin // [R19]
            next_s.lock_cnt = '0;
            next_s.locked = 1'b0;
        end else if (lnk.k_clk && !s.locked) begin // [R18]
            next_s.lock_cnt = s.lock_cnt + LOCK_W'(1);
            if (s.lock_cnt == LOCK_W'(LOCK_K_CYCLES - 1)) begin
                next_s.locked = 1'b1;
            end
        end

        // Periodic impedance evaluation, then the counter starts over
        if (s.eval_cnt == EVAL_W'(ZQ_EVAL - 1)) begin
            next_s.eval_cnt = '0;
            next_s.drv_imp = zq_step(s.drv_imp, impedance_resistor); // [R13]
            next_s.term_imp = zq_step(s.term_imp, impedance_resistor); // [R15]
        end else begin
            next_s.eval_cnt = s.eval_cnt + EVAL_W'(1);
        end

        // Termination copies the pin each cycle; a floating pin is not pulled low here
        next_s.term_on = lnk.input_termination_enable; // [R14]
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; clk_en low freezes everything including the array
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= ST_RST;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register
    assign lnk.q = s.q;
    assign lnk.q_oe = s.q_oe;
    assign locked = s.locked;
    assign term_on = s.term_on;
    assign drv_imp = s.drv_imp;
    assign term_imp = s.term_imp;

endmodule

`default_nettype wire

// file: verilog/sbp_pkg.sv
// Shared constants and types for the burst-of-four separate-I/O SRAM port
`default_nettype none

package sbp_pkg;

    // Burst shape and byte lanes
    localparam int BEATS = 4;
    localparam int BEAT_IDX_W = 2;
    localparam int LANE_W = 9;

    // Clock and power-up timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int SETTLE_TIME_US = 20;
    localparam int SETTLE_CYC =
        (SETTLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_W = 10;
    localparam int LOCK_K_CYCLES = 2048;
    localparam int LOCK_W = 12;
    localparam int CLK_STOP_NS = 30;
    localparam int CLK_STOP_CYC = (CLK_STOP_NS / CLK_PERIOD_NS < 1) ?
        1 : CLK_STOP_NS / CLK_PERIOD_NS;
    localparam int STOP_W = 4;

    // Pipeline slots, counted in ref_clk cycles after the command edge
    localparam int WR_PIPE = 5;
    localparam int WR_BEAT0_SLOT = 1;
    localparam int RD_PIPE = 7;
    localparam int RD_BEAT0_SLOT = 3;
    localparam int CTL_SLOTS = 5;
    localparam int CTL_BEAT0_SLOT = 1;

    // Impedance calibration
    localparam int ZQ_W = 5;
    localparam int ZQ_EVAL_CYC = 256;
    localparam logic [4:0] ZQ_RESET = 5'h10;

    // Controller bring-up states
    typedef enum logic [2:0] {
        CS_SETTLE = 3'h1,
        CS_LOCK = 3'h2,
        CS_RUN = 3'h4
    } sbp_ctl_state_t;

endpackage

`default_nettype wire

// file: verilog/sbp_link_if.sv
// Pin-level link between the memory controller and the SRAM device
`default_nettype none

interface sbp_link_if
    import sbp_pkg::*;
#(
    parameter int DW = 18,
    parameter int AW = 4
);
    localparam int LN = DW / LANE_W;

    // k_clk high marks a true-clock rise cycle, low a complement rise
    logic k_clk;
    logic k_run;
    logic loop_enable;
    logic input_termination_enable;
    logic rd_n;
    logic wr_n;
    logic [AW-1:0] loc_inputs;
    logic [DW-1:0] d;
    logic [LN-1:0] lane_mask_n;
    logic [DW-1:0] q;
    logic q_oe;

    modport dev (
        input k_clk, k_run, loop_enable, input_termination_enable,
        input rd_n, wr_n, loc_inputs, d, lane_mask_n,
        output q, q_oe
    );

    modport ctl (
        output k_clk, k_run, loop_enable, input_termination_enable,
        output rd_n, wr_n, loc_inputs, d, lane_mask_n,
        input q, q_oe
    );
endinterface

`default_nettype wire

// file: verilog/sbp_ctl.sv
// Memory controller end: bring-up waits, command issue, write beats, reads
`default_nettype none

module sbp_ctl
    import sbp_pkg::*;
#(
    parameter int DW = 18,
    parameter int AW = 4
) (
    // Clock, reset and freeze
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Link controls from the user
    input wire logic clk_stop,
    input wire logic loop_enable_req,
    input wire logic term_enable_req,
    // Request port
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [AW-1:0] req_addr,
    input wire logic [BEATS-1:0][DW-1:0] req_wdata,
    input wire logic [BEATS-1:0][DW/LANE_W-1:0] req_mask_n,
    output logic req_ready,
    // Read answer, one beat per pulse
    output logic rd_valid,
    output logic [DW-1:0] rd_data,
    output logic link_ready,
    // Pins toward the device
    sbp_link_if.ctl lnk
);
    localparam int LN = DW / LANE_W;

    typedef struct packed {
        sbp_ctl_state_t state;
        logic phase;
        logic run;
        logic [SETTLE_W-1:0] settle_cnt;
        logic [LOCK_W-1:0] lock_cnt;
        logic loop_en;
        logic term_en;
        logic prev_rd;
        logic prev_wr;
        logic rd_cmd;
        logic wr_cmd;
        logic [AW-1:0] loc;
        logic [CTL_SLOTS-1:0][DW-1:0] slot_d;
        logic [CTL_SLOTS-1:0][LN-1:0] slot_we;
        logic [DW-1:0] d;
        logic [LN-1:0] we;
        logic rd_valid;
        logic [DW-1:0] rd_data;
    } sbp_ctl_st_t;

    localparam sbp_ctl_st_t ST_RST = '{state: CS_SETTLE, default: '0};

    sbp_ctl_st_t s;
    sbp_ctl_st_t next_s;
    logic lock_ok;
    logic take;

    assign lock_ok = (s.lock_cnt == LOCK_W'(LOCK_K_CYCLES));

    // Offer a slot only in the half period before a true rise, and never
    // the same command type twice in a row, which the device would drop
    assign req_ready = clk_en && (s.state == CS_RUN) && lock_ok
        && !s.phase && !clk_stop && loop_enable_req
        && (req_write ? !s.prev_wr : !s.prev_rd); // [R4] [R7]
    assign take = req_valid && req_ready;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        next_s = s;
        next_s.loop_en = loop_enable_req;
        next_s.term_en = term_enable_req;
        // Divided link clock; stopping holds it low
        next_s.run = !clk_stop;
        next_s.phase = clk_stop ? 1'b0 : !s.phase;

        // Same lock count as the device, from the same pin levels
        if (!s.loop_en || !s.run) begin // [R19]
            next_s.lock_cnt = '0;
        end else if (s.phase && !lock_ok) begin // [R18]
            next_s.lock_cnt = s.lock_cnt + LOCK_W'(1);
        end

        // Bring-up: settle only once after reset, lock whenever lost
        case (s.state)
            CS_SETTLE: begin
                if (s.run) begin // [R17]
                    next_s.settle_cnt = s.settle_cnt + SETTLE_W'(1);
                    if (s.settle_cnt == SETTLE_W'(SETTLE_CYC - 1)) begin
                        next_s.state = CS_LOCK;
                    end
                end
            end
            CS_LOCK: begin
                if (lock_ok) begin
                    next_s.state = CS_RUN;
                end
            end
            CS_RUN: begin
                if (!lock_ok) begin // [R19]
                    next_s.state = CS_LOCK;
                end
            end
            default: begin
                next_s.state = CS_SETTLE;
            end
        endcase

        // Commands stand only during the true-rise half period
        next_s.rd_cmd = 1'b0;
        next_s.wr_cmd = 1'b0;
        if (!s.phase && !clk_stop) begin
            next_s.prev_rd = take && !req_write;
            next_s.prev_wr = take && req_write;
        end

        // Beat slots shift toward the pins; idle beats drive zero with
        // every lane masked, so pins never float under termination
        for (int i = 0; i < CTL_SLOTS - 1; i++) begin
            next_s.slot_d[i] = s.slot_d[i+1];
            next_s.slot_we[i] = s.slot_we[i+1];
        end
        next_s.slot_d[CTL_SLOTS-1] = '0;
        next_s.slot_we[CTL_SLOTS-1] = '0;
        next_s.d = s.slot_d[0]; // [R16]
        next_s.we = s.slot_we[0];

        if (take) begin
            next_s.rd_cmd = !req_write;
            next_s.wr_cmd = req_write;
            next_s.loc = req_addr;
            if (req_write) begin
                // Beats reach the pins two to five half periods later
                for (int k = 0; k < BEATS; k++) begin // [R8]
                    next_s.slot_d[CTL_BEAT0_SLOT + k] = req_wdata[k];
                    // Mask rides with its own beat [R9] [R12]
                    next_s.slot_we[CTL_BEAT0_SLOT + k] = ~req_mask_n[k];
                end
            end
        end

        // Capture each returned beat while the device drives it
        next_s.rd_valid = lnk.q_oe;
        if (lnk.q_oe) begin
            next_s.rd_data = lnk.q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= ST_RST;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pins and user outputs; active-low pins are inverted flops
    assign lnk.k_clk = s.phase;
    assign lnk.k_run = s.run;
    assign lnk.loop_enable = s.loop_en;
    assign lnk.input_termination_enable = s.term_en; // [R14]
    assign lnk.rd_n = !s.rd_cmd;
    assign lnk.wr_n = !s.wr_cmd;
    assign lnk.loc_inputs = s.loc;
    assign lnk.d = s.d;
    assign lnk.lane_mask_n = ~s.we;
    assign rd_valid = s.rd_valid;
    assign rd_data = s.rd_data;
    assign link_ready = (s.state == CS_RUN);

endmodule

`default_nettype wire

// file: sim/sbp_link_props.sv
// Checker of command, burst and lane-mask timing on the link
`default_nettype none

module sbp_link_props
    import sbp_pkg::*;
#(
    parameter int DW = 18,
    parameter int AW = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Link signals
    input wire logic k_clk,
    input wire logic k_run,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [DW/LANE_W-1:0] lane_mask_n,
    input wire logic [DW-1:0] q,
    input wire logic q_oe
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////
    // Commands only count at true rises
    wire logic rd_cmd = k_clk && !rd_n;
    wire logic wr_cmd = k_clk && !wr_n;

    ////////////////////////////////////////////////////////////////////////
    // Read port
    rd_burst_out_a: assert property (rd_cmd |-> ##5 q_oe [*4])
        else $error("read burst not driven four cycles");
    q_cause_a: assert property (q_oe |-> ($past(rd_cmd, 5) ||
        $past(rd_cmd, 6) || $past(rd_cmd, 7) || $past(rd_cmd, 8)))
        else $error("read data driven without a read");
    q_idle_zero_a: assert property (!q_oe |-> q == '0)
        else $error("read data not parked while off");
    rd_spacing_a: assert property (rd_cmd |-> ##2 rd_n)
        else $error("reads loaded back to back");

    ////////////////////////////////////////////////////////////////////////
    // Command port and write beats
    cmd_true_edge_a: assert property ((!rd_n || !wr_n) |-> k_clk)
        else $error("command off a true rise");
    one_cmd_a: assert property (k_clk |-> (rd_n || wr_n))
        else $error("read and write issued together");
    wr_spacing_a: assert property (wr_cmd |-> ##2 wr_n)
        else $error("writes loaded back to back");
    wr_mask_end_a: assert property ((wr_cmd ##4 !wr_cmd)
        |-> ##2 (&lane_mask_n))
        else $error("lane masks active after last beat");
    mask_cause_a: assert property (!(&lane_mask_n) |->
        ($past(wr_cmd, 2) || $past(wr_cmd, 3) || $past(wr_cmd, 4) ||
        $past(wr_cmd, 5)))
        else $error("lane mask active outside a write");
    k_toggle_a: assert property ((k_run && $past(k_run))
        |-> k_clk != $past(k_clk))
        else $error("link clock phase did not alternate");

    // Main traffic shapes
    cover property (rd_cmd ##2 wr_cmd);
    cover property (wr_cmd ##4 wr_cmd);
    cover property (q_oe [*8]);
    cover property (!k_run ##1 k_run);
endmodule

`default_nettype wire

// file: sim/separate_io_burst4_sram_port_tb_top.sv
// Bench joining both ends: bring-up, bursts, lane masks, relock, impedance
`default_nettype none

`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
    bad_count++; $display("ERROR %0t: %h != %h", $time, got, exp); end end

module separate_io_burst4_sram_port_tb_top import sbp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DW = 18;
    localparam int AW = 4;
    localparam int LN = DW / LANE_W;
    logic ref_clk, rst_n, clk_stop, loop_enable_req, term_enable_req;
    logic req_valid, req_write, req_ready, rd_valid, link_ready;
    logic locked, term_on;
    logic [AW-1:0] req_addr;
    logic [BEATS-1:0][DW-1:0] req_wdata;
    logic [BEATS-1:0][LN-1:0] req_mask_n;
    logic [DW-1:0] rd_data, exp_d;
    logic [ZQ_W-1:0] imp_ref, drv_imp, term_imp;
    logic [DW-1:0] mem [2**AW][BEATS];
    logic [DW-1:0] exp_q[$];
    int due_q[$];
    int cyc, due, bad_count, cmp_count, tk, t0, last;
    int seed = 32'hcddd4087;

    ////////////////////////////////////////////////////////////////////////
    sbp_link_if #(.DW(DW), .AW(AW)) sbp_link_if_i ();
    sbp_dev #(.DW(DW), .AW(AW), .ZQ_EVAL(4)) sbp_dev_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1),
        .lnk(sbp_link_if_i.dev), .impedance_resistor(imp_ref),
        .locked(locked), .term_on(term_on), .drv_imp(drv_imp),
        .term_imp(term_imp));
    sbp_ctl #(.DW(DW), .AW(AW)) sbp_ctl_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1),
        .clk_stop(clk_stop), .loop_enable_req(loop_enable_req),
        .term_enable_req(term_enable_req), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_mask_n(req_mask_n),
        .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data),
        .link_ready(link_ready), .lnk(sbp_link_if_i.ctl));
    sbp_link_props #(.DW(DW), .AW(AW)) sbp_link_props_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .k_clk(sbp_link_if_i.k_clk),
        .k_run(sbp_link_if_i.k_run), .rd_n(sbp_link_if_i.rd_n),
        .wr_n(sbp_link_if_i.wr_n), .q(sbp_link_if_i.q),
        .lane_mask_n(sbp_link_if_i.lane_mask_n), .q_oe(sbp_link_if_i.q_oe));

    ////////////////////////////////////////////////////////////////////////
    // Clock and cycle count
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) cyc <= cyc + 1;

    // Each read beat is paired with the oldest note and its due cycle
    always @(negedge ref_clk) begin
        if (rd_valid === 1'b1) begin
            exp_d = exp_q.pop_front();
            due = due_q.pop_front();
            `CHK(rd_data, exp_d)
            `CHK(cyc, due)
        end
    end

    task automatic finish_test();
        $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Hold the request until taken, then note what the far end must do
    task automatic issue(input logic wr, input logic [AW-1:0] a,
        input logic [BEATS*DW-1:0] wd, input logic [BEATS*LN-1:0] mk);
        @(negedge ref_clk);
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = wd;
        req_mask_n = mk;
        for (int n = 0; n < 40; n++) begin
            #1;
            if (req_ready === 1'b1) break;
            @(negedge ref_clk);
        end
        `CHK(req_ready, 1'b1)
        tk = cyc;
        @(posedge ref_clk);
        for (int k = 0; k < BEATS; k++) begin
            for (int l = 0; l < LN; l++) begin
                if (wr && !mk[k*LN+l]) begin
                    mem[a][k][l*LANE_W+:LANE_W] = wd[k*DW+l*LANE_W+:LANE_W];
                end
            end
            if (!wr) begin
                exp_q.push_back(mem[a][k]);
                due_q.push_back(tk + 7 + k);
            end
        end
        @(negedge ref_clk);
        req_valid = 1'b0;
    endtask

    // Bounded wait for bring-up; the lock alone is 2048 true rises
    task automatic wait_link();
        for (int n = 0; n < 9000 && link_ready !== 1'b1; n++) begin
            @(negedge ref_clk);
        end
        `CHK(link_ready, 1'b1)
        `CHK(cyc >= t0 + 4096, 1'b1)
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog sized for three lock waits plus traffic
    initial begin
        repeat (25000) @(posedge ref_clk);
        bad_count++;
        finish_test();
    end

    initial begin
        logic [95:0] r;
        {rst_n, clk_stop, term_enable_req, req_valid, req_write} = '0;
        {loop_enable_req, req_addr, req_wdata} = '1;
        req_mask_n = '1;
        imp_ref = 5'h13;
        repeat (5) @(negedge ref_clk);
        `CHK(drv_imp, 5'h10)
        `CHK(term_imp, 5'h10)
        rst_n = 1'b1;
        t0 = cyc;
        wait_link();
        `CHK(drv_imp, 5'h13)
        `CHK(term_imp, 5'h13)
        term_enable_req = 1'b1;
        repeat (3) @(negedge ref_clk);
        `CHK(term_on, 1'b1)
        term_enable_req = 1'b0;
        repeat (3) @(negedge ref_clk);
        `CHK(term_on, 1'b0)
        // Fill every row, then read all back; same-type pairs space out
        for (int p = 0; p < 2; p++) begin
            for (int a = 0; a < 2**AW; a++) begin
                r = {$random(seed), $random(seed), $random(seed)};
                issue(p == 0, a[AW-1:0], r[71:0], '0);
                if (a > 0) `CHK(tk - last, 4)
                last = tk;
            end
        end
        // Alternate masked writes with reads of the same row
        for (int a = 0; a < 2**AW; a++) begin
            r = {$random(seed), $random(seed), $random(seed)};
            issue(1'b1, a[AW-1:0], r[71:0], a == 0 ? 8'h46 : r[79:72]);
            last = tk;
            issue(1'b0, a[AW-1:0], '0, '1);
            `CHK(tk - last, 2)
        end
        // Loop off, then clock stopped: both must cost a full relock
        for (int m = 0; m < 2; m++) begin
            repeat (30) @(negedge ref_clk);
            if (m == 0) loop_enable_req = 1'b0;
            else clk_stop = 1'b1;
            repeat (3) @(negedge ref_clk);
            `CHK(locked, 1'b0)
            {loop_enable_req, clk_stop} = 2'b10;
            t0 = cyc;
            wait_link();
            issue(1'b0, 4'h5, '0, '1);
        end
        repeat (20) @(negedge ref_clk);
        `CHK(exp_q.size(), 0)
        finish_test();
    end
endmodule

`default_nettype wire
